//--- src/codec_clock_pkg.sv
// Package with register map, field positions, reset values and carriers of the codec clock block
// Notes on behaviour
// - Source bit 3 picks pin or PLL.
// - Bits 6:5 give output 32/64/128/256 fs.
// - Bit 4 enables clock output pin.
// - Bits 2:1 divide input by 1-4.
// - Core clock runs only with bit 0.
// - Regulator bits 2:1 select level, reset 01.
// - Denominator is bytes 47:40 then 39:32.
// - Numerator is bytes 31:24 then 23:16.
// - Input divider X precedes feedback compare.
// - X codes mean 1, 2, 3, 4.
// - Bit 8 picks fractional R+N/M or integer.
// - Lock bit 1 reads lock, write ignored.
// - Lock bit is sticky once set.
// - PLL runs only while bit 0 set.
package codec_clock_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [15:0] ADDR_CLOCK_CTRL = 16'h4000;
  localparam logic [15:0] ADDR_REGULATOR = 16'h4001;
  localparam logic [15:0] ADDR_SYNTH = 16'h4002;
  localparam logic [2:0] SYNTH_LAST_BYTE = 3'h5; // Bytes 0..5, MSB byte first

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CORE_EN_BIT = 0;
  localparam int IN_RATE_LSB = 1;
  localparam int SRC_SEL_BIT = 3;
  localparam int OUT_EN_BIT = 4;
  localparam int OUT_RATE_LSB = 5;
  localparam int LEVEL_LSB = 1;
  localparam int DEN_HI_LSB = 40;
  localparam int DEN_LO_LSB = 32;
  localparam int NUM_HI_LSB = 24;
  localparam int NUM_LO_LSB = 16;
  localparam int INT_R_LSB = 11;
  localparam int IN_DIV_LSB = 9;
  localparam int TYPE_BIT = 8;
  localparam int LOCK_BIT = 1;
  localparam int PLL_EN_BIT = 0;

  // ****************************************************************
  // Reset values and write masks
  // ****************************************************************
  localparam logic [7:0] CLOCK_CTRL_RESET = 8'h00;
  localparam logic [7:0] CLOCK_CTRL_MASK = 8'h7F;
  localparam logic [7:0] REGULATOR_RESET = 8'h02;
  localparam logic [7:0] REGULATOR_MASK = 8'h06;
  localparam logic [47:0] SYNTH_RESET = 48'h0753_0287_1901;
  localparam logic [47:0] SYNTH_MASK = 48'hFFFF_FFFF_7F01;

  // ****************************************************************
  // Counts
  // ****************************************************************
  localparam logic [1:0] LOCK_MATCHES = 2'h2; // Reference periods matching the one before, counted before lock
  localparam int PERIOD_W = 16;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [7:0] clock_ctrl;
    logic [7:0] regulator;
    logic [47:0] synth;
    logic [39:0] stage;
    logic [1:0] pin_sync;
    logic pin_prev;
    logic [PERIOD_W-1:0] ref_cnt;
    logic [PERIOD_W-1:0] ref_period;
    logic [1:0] match_cnt;
    logic lock;
    logic [32:0] acc;
    logic pll_tick;
    logic [7:0] core_cnt;
    logic out_level;
    logic [7:0] rdata;
    logic rvalid;
  } clock_state_s;

  typedef struct packed {
    logic [2:0] count;
    logic tick;
  } div_state_s;

  // Divisor of a two-bit divide code: 00..11 give 1..4
  function automatic logic [2:0] divisor_of(input logic [1:0] code);
    divisor_of = {1'b0, code} + 3'h1;
  endfunction

endpackage

//--- src/tick_divider.sv
// Divider passing every Nth input tick, N chosen by a two-bit code
`timescale 1ns/1ps
module tick_divider
  import codec_clock_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic tick_in,
  input wire logic [1:0] div_code,
  output logic tick_out
);

  div_state_s st;
  div_state_s next_st;

  // Count input ticks and emit one tick per full count
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (tick_in) begin
      if (st.count + 3'h1 >= divisor_of(div_code)) begin
        next_st.count = 3'h0;
        next_st.tick = 1'b1;
      end else begin
        next_st.count = st.count + 3'h1;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign tick_out = st.tick;

endmodule

//--- src/codec_clock_pll_control.sv
// Clock source selection, PLL model, core divider, clock output and regulator level of the codec
`timescale 1ns/1ps
module codec_clock_pll_control
  import codec_clock_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic master_clock_in_pin,
  output logic master_clock_out,
  output logic master_clock_out_oe_n,
  output logic core_clk_tick,
  output logic core_clk_running,
  output logic pll_clk_tick,
  output logic pll_locked,
  output logic [1:0] core_supply_level
);

  clock_state_s st;
  clock_state_s next_st;

  // ****************************************************************
  // Field decode
  // ****************************************************************
  logic core_en;
  logic src_pll;
  logic out_en;
  logic [1:0] out_rate;
  logic [1:0] in_rate;
  logic pll_en;
  logic frac_mode;
  logic [1:0] in_div;
  logic [3:0] int_r;
  logic [15:0] den_m;
  logic [15:0] num_n;
  logic pin_edge;
  logic ref_tick;
  logic src_tick;
  logic core_tick_raw;
  logic [2:0] byte_idx;
  logic synth_hit;
  logic [47:0] synth_view;

  assign core_en = st.clock_ctrl[CORE_EN_BIT];
  assign src_pll = st.clock_ctrl[SRC_SEL_BIT];
  assign out_en = st.clock_ctrl[OUT_EN_BIT];
  assign out_rate = st.clock_ctrl[OUT_RATE_LSB +: 2];
  assign in_rate = st.clock_ctrl[IN_RATE_LSB +: 2];
  assign pll_en = st.synth[PLL_EN_BIT];
  assign frac_mode = st.synth[TYPE_BIT];
  assign in_div = st.synth[IN_DIV_LSB +: 2];
  assign int_r = st.synth[INT_R_LSB +: 4];
  assign den_m = {st.synth[DEN_HI_LSB +: 8], st.synth[DEN_LO_LSB +: 8]};
  assign num_n = {st.synth[NUM_HI_LSB +: 8], st.synth[NUM_LO_LSB +: 8]};

  // Rising edge of the synchronised pin, taken only from the second stage
  assign pin_edge = st.pin_sync[1] & ~st.pin_prev;

  // Lock is never stored in the synth register; the register view merges it in on reads
  always_comb begin
    synth_view = st.synth;
    synth_view[LOCK_BIT] = st.lock;
  end

  assign byte_idx = reg_req.addr[2:0] - ADDR_SYNTH[2:0];
  assign synth_hit = (reg_req.addr >= ADDR_SYNTH) && (reg_req.addr <= ADDR_SYNTH + {13'h0, SYNTH_LAST_BYTE});

  // ****************************************************************
  // Dividers
  // ****************************************************************
  // Reference divider in front of the feedback comparison
  tick_divider ref_div (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .tick_in(pin_edge & pll_en),
    .div_code(in_div),
    .tick_out(ref_tick)
  );

  // Source select feeds the core divider
  assign src_tick = src_pll ? st.pll_tick : pin_edge;

  // Core divider brings the source down to 256 fs
  tick_divider core_div (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .tick_in(src_tick),
    .div_code(in_rate),
    .tick_out(core_tick_raw)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [32:0] inc;
    logic [32:0] modv;
    logic [32:0] sum;
    logic commit;
    inc = '0;
    modv = '0;
    sum = '0;
    commit = 1'b0;
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.pll_tick = 1'b0;
    next_st.pin_sync = {st.pin_sync[0], master_clock_in_pin};
    next_st.pin_prev = st.pin_sync[1];

    // Register writes; the wide register only changes on its last byte
    if (reg_req.wr) begin
      if (reg_req.addr == ADDR_CLOCK_CTRL) begin
        next_st.clock_ctrl = reg_req.wdata & CLOCK_CTRL_MASK;
      end else if (reg_req.addr == ADDR_REGULATOR) begin
        next_st.regulator = reg_req.wdata & REGULATOR_MASK;
      end else if (synth_hit) begin
        if (byte_idx == SYNTH_LAST_BYTE) begin
          // Atomic commit keeps the PLL from ever seeing a half-written set
          next_st.synth = {st.stage, reg_req.wdata} & SYNTH_MASK;
          commit = 1'b1;
        end else begin
          next_st.stage[8*(4-byte_idx) +: 8] = reg_req.wdata;
        end
      end
    end

    // Register reads, answered one cycle later; unmapped reads give zero
    if (reg_req.rd) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = 8'h00;
      if (reg_req.addr == ADDR_CLOCK_CTRL) begin
        next_st.rdata = st.clock_ctrl;
      end else if (reg_req.addr == ADDR_REGULATOR) begin
        next_st.rdata = st.regulator;
      end else if (synth_hit) begin
        next_st.rdata = synth_view[8*(5-byte_idx) +: 8];
      end
    end

    // Reference period measurement and lock detection
    if (!pll_en) begin
      next_st.ref_cnt = '0;
      next_st.match_cnt = 2'h0;
      next_st.acc = '0;
    end else begin
      if (st.ref_cnt != {PERIOD_W{1'b1}}) begin
        next_st.ref_cnt = st.ref_cnt + 1'b1;
      end
      if (ref_tick) begin
        next_st.ref_cnt = '0;
        next_st.ref_period = st.ref_cnt + 1'b1;
        if (st.ref_cnt + 1'b1 == st.ref_period) begin
          if (st.match_cnt != LOCK_MATCHES) begin
            next_st.match_cnt = st.match_cnt + 2'h1;
          end
        end else begin
          next_st.match_cnt = 2'h0;
        end
      end
      if (st.match_cnt == LOCK_MATCHES) begin
        next_st.lock = 1'b1;
      end
    end

    // Synthesised output as a phase accumulator: R + N/M ticks per reference period
    if (frac_mode && den_m != 16'h0000) begin
      inc = 33'({int_r} * {16'h0, den_m} + {16'h0, num_n});
      modv = 33'({16'h0, st.ref_period} * {16'h0, den_m});
    end else begin
      inc = 33'(int_r);
      modv = 33'(st.ref_period);
    end
    if (pll_en && st.match_cnt == LOCK_MATCHES) begin
      sum = st.acc + inc;
      if (sum >= modv) begin
        next_st.acc = sum - modv;
        next_st.pll_tick = 1'b1;
      end else begin
        next_st.acc = sum;
      end
    end else begin
      next_st.acc = '0;
    end
    // A new parameter set restarts the phase, so a residue left from a larger modulus cannot burst ticks
    if (commit) begin
      next_st.acc = '0;
    end

    // Core tick counter gives the 32/64/128 fs outputs as plain bits
    if (!core_en) begin
      next_st.core_cnt = 8'h00;
    end else if (core_tick_raw) begin
      next_st.core_cnt = st.core_cnt + 8'h01;
    end

    // Clock output level; 256 fs is a one-cycle high per core tick, so its duty is not 50 %
    case (out_rate)
      2'h0: next_st.out_level = next_st.core_cnt[2];
      2'h1: next_st.out_level = next_st.core_cnt[1];
      2'h2: next_st.out_level = next_st.core_cnt[0];
      2'h3: next_st.out_level = core_en & core_tick_raw;
      default: next_st.out_level = 1'b0;
    endcase
    // Gate with the enables being written, so a pin switched off never shows a last high
    if (!next_st.clock_ctrl[OUT_EN_BIT] || !next_st.clock_ctrl[CORE_EN_BIT]) begin
      next_st.out_level = 1'b0;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
      st.clock_ctrl <= CLOCK_CTRL_RESET;
      st.regulator <= REGULATOR_RESET;
      st.synth <= SYNTH_RESET & SYNTH_MASK;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata = st.rdata;
  assign reg_rvalid = st.rvalid;
  assign master_clock_out = st.out_level;
  assign master_clock_out_oe_n = ~out_en;
  assign core_clk_tick = core_tick_raw & core_en;
  assign core_clk_running = core_en;
  assign pll_clk_tick = st.pll_tick;
  assign pll_locked = st.lock;
  assign core_supply_level = st.regulator[LEVEL_LSB +: 2];

endmodule

//--- tb/codec_clock_pll_control_assertions.sv
// Port checker for the codec clock block, bound to its top module
`timescale 1ns/1ps
module clock_ctrl_checker
  import codec_clock_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire reg_req_s reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic master_clock_out,
  input wire logic master_clock_out_oe_n,
  input wire logic core_clk_tick,
  input wire logic core_clk_running,
  input wire logic pll_locked,
  input wire logic [1:0] core_supply_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // ******
  // Requests
  // ******
  sequence ctrl_wr;
    ce && reg_req.wr && reg_req.addr == ADDR_CLOCK_CTRL;
  endsequence
  sequence rd_taken;
    ce && reg_req.rd;
  endsequence

  // Answers and register effects, one cycle after the request is taken
  read_answer_a: assert property (rd_taken |=> reg_rvalid)
    else $error("read not answered");
  answer_once_a: assert property (ce && !reg_req.rd |=> !reg_rvalid)
    else $error("answer without read");
  oe_follow_a: assert property (ctrl_wr |=> master_clock_out_oe_n == !$past(reg_req.wdata[OUT_EN_BIT]))
    else $error("output enable wrong");
  core_follow_a: assert property (ctrl_wr |=> core_clk_running == $past(reg_req.wdata[CORE_EN_BIT]))
    else $error("core enable wrong");
  level_write_a: assert property (ce && reg_req.wr && reg_req.addr == ADDR_REGULATOR
    |=> core_supply_level == $past(reg_req.wdata[2:1]))
    else $error("level not taken");
  level_read_a: assert property (rd_taken ##0 (reg_req.addr == ADDR_REGULATOR && !reg_req.wr)
    |=> reg_rdata == {5'h00, core_supply_level, 1'b0})
    else $error("level read wrong");

  // Gating: a stopped core or a disabled pin never shows activity
  tick_gate_a: assert property (!core_clk_running |-> !core_clk_tick && !master_clock_out)
    else $error("tick while core off");
  pin_off_a: assert property (master_clock_out_oe_n |-> !master_clock_out)
    else $error("output while disabled");

  // Lock flag never drops on its own and reads back as seen
  lock_sticky_a: assert property (pll_locked |=> pll_locked)
    else $error("lock dropped");
  lock_read_a: assert property (rd_taken ##0 reg_req.addr == ADDR_SYNTH + 16'h0005
    |=> reg_rdata[LOCK_BIT] == $past(pll_locked))
    else $error("lock bit read wrong");
endmodule

bind codec_clock_pll_control clock_ctrl_checker clock_ctrl_checker_i (.clk(clk), .srst(srst), .ce(ce),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .master_clock_out(master_clock_out),
  .master_clock_out_oe_n(master_clock_out_oe_n), .core_clk_tick(core_clk_tick),
  .core_clk_running(core_clk_running), .pll_locked(pll_locked), .core_supply_level(core_supply_level));

//--- tb/codec_clock_pll_control_bench.sv
// Self-checking bench for the codec clock block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module codec_clock_pll_control_bench
  import codec_clock_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic pin = 1'b0;
  reg_req_s req = '0;
  logic [7:0] rdata;
  logic rvalid, mco, oe_n, ctick, crun, ptick, lock;
  logic [1:0] lvl;
  int bad_count = 0;
  int checks = 0;
  int ct, pt, mr;
  logic [7:0] rst_img [6] = '{8'h07, 8'h53, 8'h02, 8'h87, 8'h19, 8'h01};
  logic [47:0] cfg [3] = '{48'h0000_0000_1001, 48'h0000_0000_1201, 48'h0002_0001_1101};
  int rate [3] = '{100, 50, 125};

  codec_clock_pll_control codec_clock_pll_control_i (.clk(clk), .srst(srst), .ce(ce), .reg_req(req),
    .reg_rdata(rdata), .reg_rvalid(rvalid), .master_clock_in_pin(pin), .master_clock_out(mco),
    .master_clock_out_oe_n(oe_n), .core_clk_tick(ctick), .core_clk_running(crun), .pll_clk_tick(ptick),
    .pll_locked(lock), .core_supply_level(lvl));

  // ******
  // Clocks: the pin clock runs free at 8 system cycles, off the sampling edge
  // ******
  always #5 clk = ~clk;
  always #40 pin = ~pin;

  // Requests idle one cycle apart so a single task never drives req twice in a step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 req = {1'b1, 1'b0, a, d};
    @(posedge clk);
    #1 req = '0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    #1 req = {1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    #1 req = '0;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
  endtask

  // Six bytes back to back, most significant first, as the commit needs
  task automatic synth(input logic [47:0] v);
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      #1 req = {1'b1, 1'b0, ADDR_SYNTH + 16'(i), v[47 - 8 * i -: 8]};
      @(posedge clk);
    end
    #1 req = '0;
  endtask

  // Counts core ticks, PLL ticks and output rises over n cycles
  task automatic measure(input int n);
    logic prev;
    ct = 0;
    pt = 0;
    mr = 0;
    prev = mco;
    repeat (n) begin
      @(posedge clk);
      #1;
      ct += (ctick === 1'b1) ? 1 : 0;
      pt += (ptick === 1'b1) ? 1 : 0;
      mr += (mco === 1'b1 && prev !== 1'b1) ? 1 : 0;
      prev = mco;
    end
  endtask

  // Rates are sampled on a free-running pin, so a small phase slack is allowed
  task automatic near(input string nm, input int e, input int g);
    `CHK(nm, e, (g >= e - 2 && g <= e + 2) ? e : g)
  endtask

  task automatic complete_run();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Main sequence; synth bytes are read first, before the reset PLL can lock
  initial begin
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(ADDR_SYNTH + 16'(i), rst_img[i]);
    end
    `CHK("oe_n", 1'b1, oe_n)
    `CHK("run", 1'b0, crun)
    rd(ADDR_CLOCK_CTRL, CLOCK_CTRL_RESET);
    rd(ADDR_REGULATOR, REGULATOR_RESET);
    wr(16'h4008, 8'hFF);
    rd(16'h4008, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_REGULATOR, 8'hF9 | 8'(c << 1));
      rd(ADDR_REGULATOR, 8'(c << 1));
      `CHK("level", 2'(c), lvl)
    end
    // A write while the clock enable is low must leave every register as it was
    ce = 1'b0;
    wr(ADDR_REGULATOR, 8'h00);
    ce = 1'b1;
    rd(ADDR_REGULATOR, 8'h06);
    wr(ADDR_REGULATOR, 8'h00);
    `CHK("level 1v5", 2'h0, lvl)
    rd(ADDR_SYNTH + 16'h0005, 8'h03);
    wr(ADDR_CLOCK_CTRL, 8'hFF);
    rd(ADDR_CLOCK_CTRL, 8'h7F);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CLOCK_CTRL, 8'h71 | 8'(c << 1));
      measure(48);
      measure(384);
      near("core ticks", 48 / (c + 1), ct);
      near("out 256", 48 / (c + 1), mr);
    end
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CLOCK_CTRL, 8'h11 | 8'(c << 5));
      measure(512);
      near("out rises", 8 << c, mr);
    end
    wr(ADDR_CLOCK_CTRL, 8'h61);
    measure(256);
    `CHK("oe_n off", 1'b1, oe_n)
    near("out off", 0, mr);
    wr(ADDR_CLOCK_CTRL, 8'h70);
    measure(256);
    near("core off", 0, ct + mr);
    wr(ADDR_CLOCK_CTRL, 8'h0F);
    for (int k = 0; k < 3; k++) begin
      synth(cfg[k]);
      measure(200);
      rd(ADDR_SYNTH + 16'h0005, 8'h03);
      measure(400);
      near("pll ticks", rate[k], pt);
      near("pll core", rate[k] / 4, ct);
    end
    rd(ADDR_SYNTH + 16'h0001, 8'h02);
    rd(ADDR_SYNTH + 16'h0003, 8'h01);
    synth(48'h0002_0001_1100);
    measure(200);
    near("pll off", 0, pt);
    `CHK("lock", 1'b1, lock)
    complete_run();
  end

  // Watchdog well beyond the roughly 64 us the sequence needs
  initial begin
    #200us;
    bad_count++;
    complete_run();
  end
endmodule
